//--- core/fault_manager.sv
// fault management for a flyback led driver controller
// Function
// - ground fault 200 us stops gate drive
// - zero-cross low 90 ms: 4 s off, restart
// - four overlimit pulses means winding short, recover
// - auto-recovery waits 4 s between bursts
// - supply overvoltage stops pulses, enters recovery
// - fast ovp after 4 cycles, 2 if slow
// - overheat stops until cool release
// - brown-out inhibits until line and supply good
// - impedance test blocks pulses at cold start
// - grounded sense: 20 us on cap, retest
// - line ovp stops; 340 ms low restarts cleanly
// - line below off level 25 ms shuts down
module fault_manager #(
	parameter int unsigned RECOVERY_CYCLES = 32'(fault_pkg::RECOVERY_CYC),
	parameter int unsigned SHORT_CYCLES = fault_pkg::SHORT_DETECT_CYC,
	parameter int unsigned LINE_RST_CYCLES = fault_pkg::LINE_OVP_RST_CYC,
	parameter int unsigned BROWNOUT_CYCLES = fault_pkg::BROWNOUT_CYC
) (
	input wire logic clk_i,
	input wire logic nrst_i,
	input wire logic pulse_req_i,
	input wire logic gnd_diode_i,
	input wire logic zero_cross_sense_low_i,
	input wire logic cs_stop_i,
	input wire logic supply_ovp_i,
	input wire logic fast_ovp_i,
	input wire logic slow_ovp_seen_i,
	input wire logic die_overheat_shutdown_i,
	input wire logic die_cool_i,
	input wire logic line_sense_low_i,
	input wire logic line_adequate_i,
	input wire logic supply_turn_on_i,
	input wire logic cs_above_low_i,
	input wire logic line_ovp_i,
	output logic gate_drive_out_o,
	output logic test_current_en_o,
	output logic recovering_o,
	output logic fault_latched_o
);
	fault_pkg::state_t state_q, state_d;
	logic gate_q, gate_d;
	logic [fault_pkg::CNT_W-1:0] on_cnt_q;
	logic [2:0] stop_cnt_q, ovp_cnt_q;
	logic heat_q;
	logic gnd_q;
	logic test_q, rec_q, lat_q;

	// a timer flags on the nth consecutive cycle of its condition
	function automatic logic [fault_pkg::CNT_W-1:0] last_cycle(input int unsigned n);
		return n - 1;
	endfunction

	timer_if gnd_t();
	timer_if short_t();
	timer_if rec_t();
	timer_if lrst_t();
	timer_if brown_t();

	assign gnd_t.cond = gnd_diode_i;
	assign gnd_t.clear = gnd_q;
	assign gnd_t.limit = last_cycle(fault_pkg::GND_FAULT_CYC);
	// output short persistence, counted only while running
	assign short_t.cond = zero_cross_sense_low_i;
	assign short_t.clear = state_q != fault_pkg::ST_RUN;
	assign short_t.limit = last_cycle(SHORT_CYCLES);
	assign rec_t.cond = state_q == fault_pkg::ST_RECOVER;
	assign rec_t.clear = 1'b0;
	assign rec_t.limit = last_cycle(RECOVERY_CYCLES);
	// line reset wait, must last beyond the span
	assign lrst_t.cond = !line_ovp_i;
	assign lrst_t.clear = state_q != fault_pkg::ST_LINEOVP;
	assign lrst_t.limit = 32'(LINE_RST_CYCLES);
	assign brown_t.cond = line_sense_low_i;
	assign brown_t.clear = 1'b0;
	assign brown_t.limit = last_cycle(BROWNOUT_CYCLES);

	persist_timer u_gnd (.clk_i(clk_i), .nrst_i(nrst_i), .t(gnd_t));
	persist_timer u_short (.clk_i(clk_i), .nrst_i(nrst_i), .t(short_t));
	persist_timer u_rec (.clk_i(clk_i), .nrst_i(nrst_i), .t(rec_t));
	persist_timer u_lrst (.clk_i(clk_i), .nrst_i(nrst_i), .t(lrst_t));
	persist_timer u_brown (.clk_i(clk_i), .nrst_i(nrst_i), .t(brown_t));

	// pulse end: gate was high and falls
	logic pulse_end;
	assign pulse_end = gate_q && !gate_d;
	// winding or diode short on fourth overlimit pulse
	logic winding_short;
	assign winding_short = pulse_end && cs_stop_i && stop_cnt_q == fault_pkg::STOP_PULSES - 3'h1;
	// threshold depends on slow ovp history
	logic [2:0] ovp_need;
	assign ovp_need = slow_ovp_seen_i ? fault_pkg::FAST_OVP_AFTER_SLOW : fault_pkg::FAST_OVP_FRESH;
	logic fast_ovp_fault;
	// at or past the need: slow history arriving mid-count must not wrap it
	assign fast_ovp_fault = pulse_end && fast_ovp_i && ovp_cnt_q >= ovp_need - 3'h1;
	// on-time cap reached with sense stuck low
	logic max_on;
	assign max_on = gate_q && on_cnt_q >= last_cycle(fault_pkg::MAX_ON_CYC);
	logic cs_retest;
	assign cs_retest = max_on && !cs_above_low_i;
	logic to_recover;
	assign to_recover = supply_ovp_i || short_t.expired || winding_short || fast_ovp_fault;
	logic brown;
	assign brown = brown_t.expired;
	logic heat_d;
	assign heat_d = die_overheat_shutdown_i || (heat_q && !die_cool_i);
	// ground fault is latched, supply cycle clears
	logic gnd_d;
	assign gnd_d = gnd_q || gnd_t.expired;
	logic inhibit;
	assign inhibit = gnd_d || heat_d || brown || line_ovp_i || to_recover;

	// state selection
	always_comb begin
		state_d = state_q;
		case (state_q)
			fault_pkg::ST_IMPTEST: begin
				// wait for sense pin to rise
				if (cs_above_low_i && !brown && line_adequate_i && supply_turn_on_i) begin
					state_d = fault_pkg::ST_RUN;
				end
			end
			fault_pkg::ST_RUN: begin
				if (line_ovp_i) begin
					state_d = fault_pkg::ST_LINEOVP;
				end else if (brown || heat_d) begin
					state_d = fault_pkg::ST_HOLD;
				end else if (to_recover) begin
					state_d = fault_pkg::ST_RECOVER;
				end else if (cs_retest) begin
					state_d = fault_pkg::ST_IMPTEST;
				end
			end
			fault_pkg::ST_RECOVER: begin
				if (rec_t.expired) begin
					state_d = fault_pkg::ST_IMPTEST;
				end
			end
			fault_pkg::ST_HOLD: begin
				// brown-out or heat clear leads to retest
				if (!brown && !heat_d && line_adequate_i && supply_turn_on_i) begin
					state_d = fault_pkg::ST_IMPTEST;
				end
			end
			fault_pkg::ST_LINEOVP: begin
				// clean start after 340 ms below reset
				if (lrst_t.expired) begin
					state_d = fault_pkg::ST_IMPTEST;
				end
			end
			default: state_d = fault_pkg::ST_IMPTEST;
		endcase
	end

	// fault overrides pulse generator, max-on ends pulse
	assign gate_d = state_q == fault_pkg::ST_RUN && !inhibit && pulse_req_i && !max_on;

	// state and gate registers
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			state_q <= fault_pkg::ST_IMPTEST;
			gate_q <= 1'b0;
			heat_q <= 1'b0;
			gnd_q <= 1'b0;
		end else begin
			state_q <= state_d;
			gate_q <= gate_d;
			heat_q <= heat_d;
			gnd_q <= gnd_d;
		end
	end

	// pulse counters, cleared on any clean pulse
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			stop_cnt_q <= 3'h0;
			ovp_cnt_q <= 3'h0;
		end else if (state_q != fault_pkg::ST_RUN) begin
			stop_cnt_q <= 3'h0;
			ovp_cnt_q <= 3'h0;
		end else if (pulse_end) begin
			stop_cnt_q <= cs_stop_i ? stop_cnt_q + 3'h1 : 3'h0;
			ovp_cnt_q <= fast_ovp_i ? ovp_cnt_q + 3'h1 : 3'h0;
		end
	end

	// on-time counter for the conduction cap
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			on_cnt_q <= '0;
		end else begin
			on_cnt_q <= gate_q ? on_cnt_q + 1'b1 : '0;
		end
	end

	// status flags registered so outputs come from flops
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			test_q <= 1'b0;
			rec_q <= 1'b0;
			lat_q <= 1'b0;
		end else begin
			test_q <= state_d == fault_pkg::ST_IMPTEST;
			rec_q <= state_d == fault_pkg::ST_RECOVER;
			lat_q <= gnd_d;
		end
	end

	assign gate_drive_out_o = gate_q;
	assign test_current_en_o = test_q;
	assign recovering_o = rec_q;
	assign fault_latched_o = lat_q;

	// gate low cycle after any inhibit
	AST_FAULT_GATE_LOW: assert property (@(posedge clk_i) disable iff (!nrst_i)
		inhibit |=> !gate_drive_out_o) else $error("gate high after fault");
	AST_IMPTEST_NO_GATE: assert property (@(posedge clk_i) disable iff (!nrst_i)
		state_q == fault_pkg::ST_IMPTEST |=> !gate_drive_out_o) else $error("gate during test");
	// supply ovp leaves run for recovery
	AST_SUPPLY_OVP: assert property (@(posedge clk_i) disable iff (!nrst_i)
		state_q == fault_pkg::ST_RUN && supply_ovp_i && !line_ovp_i && !brown && !heat_d
		|=> state_q == fault_pkg::ST_RECOVER) else $error("supply ovp not handled");
	sequence s_enter_rec;
		state_q != fault_pkg::ST_RECOVER ##1 state_q == fault_pkg::ST_RECOVER;
	endsequence
	AST_RECOVER_HOLD: assert property (@(posedge clk_i) disable iff (!nrst_i)
		s_enter_rec |-> (state_q == fault_pkg::ST_RECOVER) [*8]) else $error("recovery too short");
	// fourth overlimit pulse goes to recovery
	AST_WINDING: assert property (@(posedge clk_i) disable iff (!nrst_i)
		winding_short && state_q == fault_pkg::ST_RUN && !line_ovp_i && !brown && !heat_d
		|=> state_q == fault_pkg::ST_RECOVER) else $error("winding short missed");
	// fresh fast ovp needs the full count
	AST_FAST_OVP: assert property (@(posedge clk_i) disable iff (!nrst_i)
		fast_ovp_fault && !slow_ovp_seen_i |-> ovp_cnt_q == fault_pkg::FAST_OVP_FRESH - 3'h1)
		else $error("ovp count");
	// fast ovp fault leads to recovery
	AST_FAST_OVP_RECOVER: assert property (@(posedge clk_i) disable iff (!nrst_i)
		fast_ovp_fault && state_q == fault_pkg::ST_RUN && !line_ovp_i && !brown && !heat_d
		|=> state_q == fault_pkg::ST_RECOVER) else $error("fast ovp missed");
	AST_MAX_ON: assert property (@(posedge clk_i) disable iff (!nrst_i)
		on_cnt_q <= 32'(fault_pkg::MAX_ON_CYC)) else $error("on-time over cap");
	// overheat keeps gate off until cool
	AST_HEAT: assert property (@(posedge clk_i) disable iff (!nrst_i)
		heat_q && !die_cool_i |=> !gate_drive_out_o) else $error("gate while hot");
	// latched ground fault keeps gate off
	AST_GND: assert property (@(posedge clk_i) disable iff (!nrst_i)
		gnd_q |-> !gate_drive_out_o) else $error("gate after ground fault");
	AST_LINE_OVP: assert property (@(posedge clk_i) disable iff (!nrst_i)
		line_ovp_i |=> !gate_drive_out_o) else $error("gate during line ovp");
endmodule

//--- core/fault_pkg.sv
// constants and types for the led driver fault manager
package fault_pkg;
	localparam int unsigned CLK_HZ = 40000000;
	// times as printed, in their own unit
	localparam int unsigned GND_FAULT_US = 200;
	localparam int unsigned SHORT_DETECT_MS = 90;
	localparam int unsigned RECOVERY_S = 4;
	localparam int unsigned LINE_OVP_RST_MS = 340;
	localparam int unsigned BROWNOUT_MS = 25;
	localparam int unsigned MAX_ON_US = 20;
	// derived cycle counts
	localparam int unsigned GND_FAULT_CYC = GND_FAULT_US * (CLK_HZ / 1000000);
	localparam int unsigned SHORT_DETECT_CYC = SHORT_DETECT_MS * (CLK_HZ / 1000);
	localparam longint unsigned RECOVERY_CYC = longint'(RECOVERY_S) * CLK_HZ;
	localparam int unsigned LINE_OVP_RST_CYC = LINE_OVP_RST_MS * (CLK_HZ / 1000);
	localparam int unsigned BROWNOUT_CYC = BROWNOUT_MS * (CLK_HZ / 1000);
	localparam int unsigned MAX_ON_CYC = MAX_ON_US * (CLK_HZ / 1000000);
	// pulse-count thresholds
	localparam logic [2:0] STOP_PULSES = 3'h4;
	localparam logic [2:0] FAST_OVP_FRESH = 3'h4;
	localparam logic [2:0] FAST_OVP_AFTER_SLOW = 3'h2;
	localparam int CNT_W = 32;
	// top-level states, one-hot
	typedef enum logic [4:0] {
		ST_IMPTEST = 5'h01,
		ST_RUN = 5'h02,
		ST_RECOVER = 5'h04,
		ST_HOLD = 5'h08,
		ST_LINEOVP = 5'h10
	} state_t;
endpackage

//--- core/persist_timer.sv
// counts cycles a condition holds continuously, flags reaching a limit
module persist_timer (
	input wire logic clk_i,
	input wire logic nrst_i,
	timer_if.timer t
);
	logic [fault_pkg::CNT_W-1:0] cnt_q;
	logic [fault_pkg::CNT_W-1:0] cnt_d;
	logic at_limit;
	assign at_limit = (cnt_q >= t.limit);
	// any drop of the condition restarts the count
	assign cnt_d = (t.clear || !t.cond) ? '0 : (at_limit ? cnt_q : cnt_q + 1'b1);
	assign t.expired = t.cond && !t.clear && at_limit;
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			cnt_q <= '0;
		end else begin
			cnt_q <= cnt_d;
		end
	end
endmodule

//--- core/timer_if.sv
// bundle joining the fault manager to its persistence timer
interface timer_if;
	logic cond;
	logic clear;
	logic [fault_pkg::CNT_W-1:0] limit;
	logic expired;
	modport owner(output cond, output clear, output limit, input expired);
	modport timer(input cond, input clear, input limit, output expired);
endinterface

//--- tb/flyback_stage.sv
// flyback power stage stand-in that answers the gate with sense flags
module flyback_stage (
	input wire logic gate_i,
	input wire logic test_current_i,
	input wire logic overlimit_i,
	input wire logic overshoot_i,
	input wire logic pin_ok_i,
	output logic cs_stop_o,
	output logic fast_ovp_o,
	output logic cs_above_low_o
);
	timeunit 1ns;
	timeprecision 1ps;
	// flags for pulse end; stop level only trips while conducting
	assign cs_stop_o = overlimit_i & gate_i; // shorted winding trips every pulse
	assign fast_ovp_o = overshoot_i;
	// pin rises only with current into it and no short to ground
	assign cs_above_low_o = pin_ok_i & (test_current_i | gate_i);
endmodule

//--- tb/tb_led_driver_fault_manager.sv
// self-checking bench for the led driver fault manager
module tb_led_driver_fault_manager;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int REC = 50;
	localparam int SHT = 40;
	localparam int LRST = 30;
	localparam int BRO = 20;
	logic clk_i = 1'b0, nrst_i = 1'b0, req = 1'b0, gnd = 1'b0, zlow = 1'b0, ovl = 1'b0;
	logic ovs = 1'b0, pin_ok = 1'b0, sovp = 1'b0, slow = 1'b0, hot = 1'b0, cool = 1'b0;
	logic lsl = 1'b0, ladq = 1'b0, son = 1'b0, lovp = 1'b0;
	logic gate, tce, rec, flt, cs_stop, fovp, cs_low;
	int bad_count = 0;
	int n_checks = 0;
	logic [31:0] seed = 32'h0c7bc0d5;
	fault_manager #(.RECOVERY_CYCLES(REC), .SHORT_CYCLES(SHT), .LINE_RST_CYCLES(LRST),
		.BROWNOUT_CYCLES(BRO)) uut (.clk_i(clk_i), .nrst_i(nrst_i), .pulse_req_i(req),
		.gnd_diode_i(gnd), .zero_cross_sense_low_i(zlow), .cs_stop_i(cs_stop),
		.supply_ovp_i(sovp), .fast_ovp_i(fovp), .slow_ovp_seen_i(slow),
		.die_overheat_shutdown_i(hot), .die_cool_i(cool), .line_sense_low_i(lsl),
		.line_adequate_i(ladq), .supply_turn_on_i(son), .cs_above_low_i(cs_low),
		.line_ovp_i(lovp), .gate_drive_out_o(gate), .test_current_en_o(tce),
		.recovering_o(rec), .fault_latched_o(flt));
	flyback_stage stage (.gate_i(gate), .test_current_i(tce), .overlimit_i(ovl), .overshoot_i(ovs),
		.pin_ok_i(pin_ok), .cs_stop_o(cs_stop), .fast_ovp_o(fovp), .cs_above_low_o(cs_low));
	// 40 MHz clock
	initial begin
		forever #12.5 clk_i = ~clk_i;
	end
	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] v;
		v = s ^ (s << 13);
		v = v ^ (v >> 17);
		return v ^ (v << 5);
	endfunction
	// pulses to a fast ovp fault: four, or two once slow ovp has tripped
	function automatic int need_pulses(input logic slow_seen);
		return slow_seen ? 2 : 4;
	endfunction
	// inputs move a fixed 2 ns after the edge
	task automatic cyc(input int n);
		repeat (n) @(posedge clk_i);
		#2;
	endtask
	task automatic chk(input logic got, input logic exp, input string m);
		n_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("mismatch t=%0t %s", $time, m);
		end
	endtask
	function automatic logic fl(input int k);
		logic [3:0] v;
		v = {flt, rec, tce, gate};
		return v[k];
	endfunction
	// bounded wait for an output to reach a level
	task automatic await(input int k, input logic v, input int lim, input string m);
		int i;
		i = 0;
		while (fl(k) !== v && i < lim) begin
			cyc(1);
			i++;
		end
		chk(fl(k), v, m);
	endtask
	task automatic to_run();
		pin_ok = 1'b1;
		ladq = 1'b1;
		son = 1'b1;
		await(1, 1'b0, REC + 20, "leave test");
		cyc(2);
	endtask
	// random pulse width keeps pulse ends irregular
	task automatic pulse();
		seed = xs(seed);
		req = 1'b1;
		cyc(2 + int'(seed[2:0]));
		req = 1'b0;
		cyc(3);
	endtask
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	initial begin
		cyc(30000);
		bad_count++;
		report_and_stop();
	end
	initial begin
		int n;
		repeat (2) @(posedge clk_i);
		#2 nrst_i = 1'b1;
		cyc(1);
		chk(tce, 1'b1, "test current at start");
		req = 1'b1;
		cyc(4);
		chk(gate, 1'b0, "gate during pin test");
		req = 1'b0;
		to_run();
		req = 1'b1;
		cyc(1);
		chk(gate, 1'b1, "gate follows request");
		sovp = 1'b1;
		cyc(1);
		chk(gate, 1'b0, "fault drops gate");
		req = 1'b0;
		await(2, 1'b1, 5, "supply ovp recovery");
		// recovery flag stands exactly the recovery span
		cyc(REC - 1);
		chk(rec, 1'b1, "recovery span");
		sovp = 1'b0;
		cyc(1);
		chk(rec, 1'b0, "recovery ends on time");
		chk(tce, 1'b1, "restart after recovery");
		$display("test supply ovp done");
		// overlimit, fresh fast ovp, fast ovp after slow
		for (int k = 0; k < 3; k++) begin
			n = need_pulses(k == 2);
			to_run();
			ovl = (k == 0);
			ovs = (k != 0);
			slow = (k == 2);
			repeat (n - 1) pulse();
			chk(rec, 1'b0, "early stop count");
			pulse();
			await(2, 1'b1, 5, "stop count recovery");
			{ovl, ovs, slow} = 3'h0;
			await(1, 1'b1, REC + 10, "count recovery end");
			$display("test pulse count %0d done", k);
		end
		to_run();
		zlow = 1'b1;
		cyc(SHT - 3);
		chk(rec, 1'b0, "short too early");
		await(2, 1'b1, 8, "output short");
		zlow = 1'b0;
		await(1, 1'b1, REC + 10, "short restart");
		$display("test output short done");
		to_run();
		req = 1'b1;
		hot = 1'b1;
		cyc(1);
		chk(gate, 1'b0, "overheat stop");
		hot = 1'b0;
		cyc(10);
		chk(gate, 1'b0, "off until cool");
		cool = 1'b1;
		to_run();
		await(0, 1'b1, 20, "resume when cool");
		{cool, req} = 2'h0;
		$display("test overheat done");
		to_run();
		lsl = 1'b1;
		cyc(BRO - 4);
		req = 1'b1;
		cyc(1);
		chk(gate, 1'b1, "brown-out not yet");
		cyc(8);
		chk(gate, 1'b0, "brown-out shutdown");
		lsl = 1'b0;
		ladq = 1'b0;
		cyc(10);
		chk(gate, 1'b0, "wait for line");
		ladq = 1'b1;
		await(1, 1'b1, 10, "pin test after brown-out");
		req = 1'b0;
		$display("test brown-out done");
		to_run();
		lovp = 1'b1;
		req = 1'b1;
		cyc(2);
		chk(gate, 1'b0, "line ovp stop");
		lovp = 1'b0;
		cyc(LRST - 3);
		chk(gate, 1'b0, "line ovp hold");
		await(0, 1'b1, 15, "line ovp restart");
		req = 1'b0;
		$display("test line ovp done");
		to_run();
		pin_ok = 1'b0;
		req = 1'b1;
		cyc(790);
		chk(gate, 1'b1, "long pulse");
		await(0, 1'b0, 20, "max on-time cut");
		cyc(1);
		chk(tce, 1'b1, "pin retest");
		req = 1'b0;
		$display("test grounded pin done");
		to_run();
		gnd = 1'b1;
		cyc(7990);
		chk(flt, 1'b0, "ground fault early");
		await(3, 1'b1, 20, "ground fault");
		gnd = 1'b0;
		req = 1'b1;
		cyc(5);
		chk(gate, 1'b0, "no gate after ground fault");
		// mid-run reset is the only way out of a ground fault
		nrst_i = 1'b0;
		cyc(2);
		chk(flt, 1'b0, "reset clears ground latch");
		chk(gate, 1'b0, "gate low in reset");
		nrst_i = 1'b1;
		cyc(1);
		chk(tce, 1'b1, "test current after reset");
		$display("test ground fault done");
		report_and_stop();
	end
endmodule
